// ### core/watchdog_unit.sv
// Purpose: standby-aware watchdog with keyed clear and one-shot mode write
// Assumes: AXI4-Lite master with one write and one read at a time
// Notes: reset request is a one-cycle pulse to the chip reset logic

`timescale 1ns/100ps

// How it works
// R1: fixed personality always counts on the low-speed oscillator.
// R2: after reset count at once, low-speed clock, longest cycle setting.
// R3: fixed personality cannot be stopped by any write.
// R4: fixed personality ignores written clock-select bits.
// R5: every mode write clears the counter.
// R6: key write to clear register zeroes the count, counting goes on.
// R7: fixed personality keeps counting through halt and stop.
// R8: overflow at the selected time raises an internal reset.
// R9: software clears the count in time during stop, from a timer.
// R10: stoppable personality picks low-speed, system clock or stopped.
// R11: mode set by full-byte writes; low three bits pick overflow.
// R12: software writes mode bits seven to five as zero, one, one.
// R13: first write stopping the unit exempts later bad writes from reset.
// R14: stoppable personality holds count in standby, resumes same clock.
// R15: stoppable personality stops in stop standby for either clock.
// R16: after stop standby, stay paused about 34 us then resume.
// R17: stoppable personality holds count in halt for either clock.
// R18: clock select 00 low-speed, 01 system, 1x stopped.
// R19: cycle 000..111 gives 2^11..2^18 low or 2^13..2^20 system clocks.
// R20: second mode write raises reset unless exempt.
// R21: non-key write or bit operation on clear register raises reset.
// R22: counter twenty bits, overflow bit chosen by cycle field.
// R23: personality strap caught after reset, held until next reset.
module watchdog_unit
	import wdt_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// axi4-lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// clock source, strap and standby state
	input wire logic low_speed_osc_clk,
	input wire logic stoppable_strap,
	input wire logic halt_mode,
	input wire logic stop_mode,
	// internal reset request
	output logic wdt_reset_req
);

	// ==========================================================
	// declarations
	logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, rdata_d;
	logic wr_fire, byte_wr, wr_mode, wr_key, wr_bitop, wr_known;
	logic strap_taken_q, stoppable_q;
	mode_cfg_type cfg_q;
	logic mode_written_q, exempt_q;
	logic [COUNT_W-1:0] cnt_q;
	logic [PAUSE_W-1:0] pause_q;
	logic stop_prev_q;
	logic osc_tick, tick, standby, running, ovf, viol, clear;
	logic reset_req_q;

	// overflow reached when all bits below the chosen exponent are set
	function automatic logic at_terminal(input logic [COUNT_W-1:0] cnt,
		input logic [2:0] cyc, input logic sys);
		logic [4:0] expo;
		logic [COUNT_W-1:0] mask;
		expo = (sys ? SYSTEM_EXP_BASE : LOW_SPEED_EXP_BASE) + {2'h0, cyc};
		mask = COUNT_W'((21'h000001 << expo) - 21'h000001);
		return (cnt & mask) == mask; // R19 R22
	endfunction : at_terminal

	// ==========================================================
	// low-speed oscillator edge detect
	lsosc_sync u_lsosc_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.low_speed_osc_clk(low_speed_osc_clk),
		.osc_tick(osc_tick)
	);

	// ==========================================================
	// axi4-lite write side: address and data taken in either order
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// write decode; only a write with the low byte lane is a byte write
	assign byte_wr = w_strb_q[0]; // R11
	assign wr_mode = wr_fire && aw_addr_q == MODE_CFG_OFS && byte_wr;
	assign wr_key = wr_fire && aw_addr_q == CLEAR_KEY_OFS && byte_wr;
	assign wr_bitop = wr_fire && aw_addr_q == CLEAR_BITOP_OFS;
	assign wr_known = aw_addr_q == MODE_CFG_OFS ||
		aw_addr_q == CLEAR_KEY_OFS || aw_addr_q == CLEAR_BITOP_OFS;

	// ==========================================================
	// axi4-lite read side
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// read mux; unmapped reads return zero
	always_comb begin
		rdata_d = 32'h00000000;
		case (s_axi_araddr)
			MODE_CFG_OFS: rdata_d[7:0] = {MODE_TOP_BITS, cfg_q};
			CLEAR_KEY_OFS: rdata_d[7:0] = CLEAR_KEY_READ;
			STATUS_OFS: begin
				rdata_d[ST_RUNNING] = running;
				rdata_d[ST_MODE_WRITTEN] = mode_written_q;
				rdata_d[ST_STOPPABLE] = stoppable_q;
				rdata_d[ST_EXEMPT] = exempt_q;
				rdata_d[ST_PAUSING] = pause_q != '0;
			end
			COUNT_OFS: rdata_d[COUNT_W-1:0] = cnt_q;
			default: rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rdata_d;
			rresp_q <= (s_axi_araddr == MODE_CFG_OFS ||
				s_axi_araddr == CLEAR_KEY_OFS ||
				s_axi_araddr == STATUS_OFS ||
				s_axi_araddr == COUNT_OFS) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// personality strap caught once after reset release
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_taken_q <= 1'b0;
			stoppable_q <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1; // R23
			stoppable_q <= stoppable_strap; // R23
		end
	end

	// ==========================================================
	// mode register: one write, then locked
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= mode_cfg_type'(MODE_CFG_RESET[4:0]); // R2
			mode_written_q <= 1'b0;
			exempt_q <= 1'b0;
		end else if (wr_mode && !mode_written_q) begin
			mode_written_q <= 1'b1;
			cfg_q.cyc_sel <= w_data_q[CYC_SEL_LSB +: 3]; // R11
			if (stoppable_q) begin
				cfg_q.clk_sel <= w_data_q[CLK_SEL_LSB +: 2]; // R10 R18
				exempt_q <= w_data_q[CLK_SEL_LSB + 1]; // R13
			end else begin
				cfg_q.clk_sel <= CLK_SEL_LOW_SPEED; // R1 R3 R4
			end
		end
	end

	// ==========================================================
	// pause after stop standby ends
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			stop_prev_q <= 1'b0;
			pause_q <= '0;
		end else begin
			stop_prev_q <= stop_mode;
			if (stop_prev_q && !stop_mode && stoppable_q) begin
				pause_q <= PAUSE_W'(STOP_PAUSE_CYC); // R16
			end else if (pause_q != '0) begin
				pause_q <= pause_q - PAUSE_W'(1);
			end
		end
	end

	// ==========================================================
	// counting conditions and reset causes
	assign standby = halt_mode || stop_mode || pause_q != '0;
	assign running = !cfg_q.clk_sel[1] &&
		(!stoppable_q || !standby); // R7 R14 R15 R17
	assign tick = running &&
		(cfg_q.clk_sel == CLK_SEL_SYSTEM ? 1'b1 : osc_tick); // R18
	assign ovf = tick && at_terminal(cnt_q, cfg_q.cyc_sel,
		cfg_q.clk_sel == CLK_SEL_SYSTEM); // R8
	assign viol = !exempt_q && ((wr_mode && mode_written_q) ||
		(wr_key && w_data_q[7:0] != CLEAR_KEY_VALUE) ||
		wr_bitop); // R13 R20 R21
	assign clear = wr_mode || (wr_key && w_data_q[7:0] == CLEAR_KEY_VALUE);

	// watchdog counter
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (clear || ovf) begin
			cnt_q <= '0; // R5 R6
		end else if (tick) begin
			cnt_q <= cnt_q + COUNT_W'(1);
		end
	end

	// reset request pulse
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reset_req_q <= 1'b0;
		end else begin
			reset_req_q <= ovf || viol; // R8 R20 R21
		end
	end

	assign wdt_reset_req = reset_req_q;

	// ==========================================================
	// assertions
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	ovf_reset_a: assert property (ovf |=> wdt_reset_req) // R8
		else $error("overflow did not raise reset");
	fixed_clock_a: assert property (strap_taken_q && !stoppable_q
		|-> cfg_q.clk_sel == CLK_SEL_LOW_SPEED) // R1
		else $error("fixed personality left low-speed clock");
	fixed_count_a: assert property (!stoppable_q && osc_tick && !clear
		&& !ovf |=> cnt_q == $past(cnt_q) + COUNT_W'(1)) // R7
		else $error("fixed personality missed a tick");
	mode_clear_a: assert property (wr_mode |=> cnt_q == '0) // R5
		else $error("mode write did not clear counter");
	key_clear_a: assert property (wr_key && !ovf && // R6
		w_data_q[7:0] == CLEAR_KEY_VALUE |=> cnt_q == '0 && !wdt_reset_req)
		else $error("key write did not clear counter");
	second_write_a: assert property (wr_mode && mode_written_q &&
		!exempt_q |=> wdt_reset_req ##1 !wdt_reset_req) // R20
		else $error("second mode write not caught");
	bad_key_a: assert property ((wr_bitop || (wr_key && // R21
		w_data_q[7:0] != CLEAR_KEY_VALUE)) && !exempt_q |=> wdt_reset_req)
		else $error("bad clear write not caught");
	exempt_a: assert property (exempt_q |-> !cfg_q.clk_sel[1] == 1'b0
		##1 !wdt_reset_req) // R13
		else $error("exempt unit raised reset");
	standby_hold_a: assert property (stoppable_q && (halt_mode ||
		stop_mode) && !clear |=> $stable(cnt_q)) // R14
		else $error("count moved in standby");
	stop_pause_a: assert property (stoppable_q && $fell(stop_mode)
		|=> pause_q == PAUSE_W'(STOP_PAUSE_CYC)) // R16
		else $error("pause after stop not loaded");

	// bus answers stand until the master takes them
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready // R11
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped before taken");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready // R11
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped before taken");

	// personality, lock and standby invariants
	strap_hold_a: assert property (strap_taken_q // R23
		|=> $stable(stoppable_q))
		else $error("personality changed after capture");
	fixed_run_a: assert property (strap_taken_q && !stoppable_q // R3
		|-> running)
		else $error("fixed personality stopped counting");
	fixed_exempt_a: assert property (!stoppable_q // R13
		|-> !exempt_q)
		else $error("fixed personality became exempt");
	mode_lock_a: assert property (wr_mode && mode_written_q // R20
		|=> $stable(cfg_q))
		else $error("locked mode register changed");
	pause_hold_a: assert property (stoppable_q && pause_q != '0 // R16
		&& !clear |=> $stable(cnt_q))
		else $error("count moved during stop pause");
	sys_count_a: assert property (stoppable_q && !standby && // R10
		cfg_q.clk_sel == CLK_SEL_SYSTEM && !clear && !ovf
		|=> cnt_q == $past(cnt_q) + COUNT_W'(1))
		else $error("system clock tick missed");

	// cover points for the main scenarios
	ovf_seen_c: cover property (ovf ##1 wdt_reset_req);
	pause_load_c: cover property (stoppable_q && $fell(stop_mode));
	exempt_seen_c: cover property (exempt_q && wr_mode);
	pause_end_c: cover property (pause_q == PAUSE_W'(1) ##1 running);

endmodule : watchdog_unit

// ### core/wdt_pkg.sv
// Purpose: shared constants and types of the watchdog unit
// Assumes: 32-bit AXI4-Lite register port, 20 MHz system clock
// Notes: every offset, field, reset value and timing count lives here

package wdt_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] MODE_CFG_OFS = 8'h00;
	localparam logic [7:0] CLEAR_KEY_OFS = 8'h04;
	localparam logic [7:0] CLEAR_BITOP_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] COUNT_OFS = 8'h10;

	// ==========================================================
	// mode register layout and values
	localparam int CYC_SEL_LSB = 0;
	localparam int CLK_SEL_LSB = 3;
	localparam logic [2:0] MODE_TOP_BITS = 3'h3;
	localparam logic [7:0] MODE_CFG_RESET = 8'h67;
	localparam logic [1:0] CLK_SEL_LOW_SPEED = 2'h0;
	localparam logic [1:0] CLK_SEL_SYSTEM = 2'h1;
	localparam logic [2:0] CYC_SEL_MAX = 3'h7;

	// ==========================================================
	// clear register values
	localparam logic [7:0] CLEAR_KEY_VALUE = 8'hAC;
	localparam logic [7:0] CLEAR_KEY_READ = 8'h9A;

	// ==========================================================
	// overflow exponents for cycle select 000
	localparam logic [4:0] LOW_SPEED_EXP_BASE = 5'h0B;
	localparam logic [4:0] SYSTEM_EXP_BASE = 5'h0D;
	localparam int COUNT_W = 20;

	// ==========================================================
	// status register bits
	localparam int ST_RUNNING = 0;
	localparam int ST_MODE_WRITTEN = 1;
	localparam int ST_STOPPABLE = 2;
	localparam int ST_EXEMPT = 3;
	localparam int ST_PAUSING = 4;

	// ==========================================================
	// timing: pause after stop standby (typical figure)
	localparam int SYS_CLK_PERIOD_NS = 50;
	localparam int STOP_PAUSE_NS = 34000;
	localparam int STOP_PAUSE_CYC = STOP_PAUSE_NS / SYS_CLK_PERIOD_NS;
	localparam int PAUSE_W = 11;

	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// mode configuration as held in the block
	typedef struct packed {
		logic [1:0] clk_sel;
		logic [2:0] cyc_sel;
	} mode_cfg_type;

endpackage : wdt_pkg

// ### core/lsosc_sync.sv
// Purpose: brings the low-speed oscillator into the system clock domain
// Assumes: oscillator well below half the system clock rate
// Notes: emits one pulse per rising oscillator edge

`timescale 1ns/100ps

module lsosc_sync (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// oscillator pin and tick out
	input wire logic low_speed_osc_clk,
	output logic osc_tick
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// ==========================================================
	// two-stage synchroniser, then edge history
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= low_speed_osc_clk;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// rising edge of the synchronised oscillator
	assign osc_tick = sync_q & ~prev_q;

endmodule : lsosc_sync

// ### core/watchdog_unit_fix_note.sv
// Purpose: none
// Assumes: none
// Notes: intentionally empty

// ### tb/tb.sv
// Purpose: self-checking bench of the standby-aware watchdog unit
// Assumes: 20 MHz sys_clk, low-speed oscillator at one eighth of it
// Notes: expected bus answers queue up; a watcher process compares

`timescale 1ns/100ps

module tb
	import wdt_pkg::*;
;
	// ==========================================================
	// design signals and bench state
	logic sys_clk, rst_b;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic low_speed_osc_clk, stoppable_strap, halt_mode, stop_mode;
	logic wdt_reset_req;
	logic [33:0] exp_q[$];
	logic [1:0] osc_div;
	logic [31:0] seed;
	int miscompares, n_tests, req_cnt, req_base;

	watchdog_unit DUT (
		.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .low_speed_osc_clk,
		.stoppable_strap, .halt_mode, .stop_mode, .wdt_reset_req
	);

	// ==========================================================
	// clocks: system clock, oscillator of eight system cycles
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		osc_div <= osc_div + 2'h1;
		if (osc_div == 2'h3) low_speed_osc_clk <= ~low_speed_osc_clk;
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs

	task check(input bit ok, input string msg);
		n_tests++;
		if (!ok) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check

	task finish_test;
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test

	// oldest noted answer against what the bus carries
	task compare(input logic [33:0] g);
		logic [33:0] e;
		e = (exp_q.size() > 0) ? exp_q.pop_front() : {34{1'bx}};
		check(g === e, $sformatf("answer %h, expected %h", g, e));
	endtask : compare

	// watcher: takes a note off the queue at each bus answer
	always @(posedge sys_clk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready)
			compare({s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid === 1'b1 && s_axi_bready)
			compare({s_axi_bresp, 32'h0});
		if (wdt_reset_req === 1'b1) req_cnt++;
	end

	// ==========================================================
	// bus tasks: valid held until taken, ready held until answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] r);
		int n;
		exp_q.push_back({r, 32'h0});
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50) begin
			check(1'b0, "write not answered");
			finish_test;
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		exp_q.push_back({r, d});
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 50) begin
			check(1'b0, "read not answered");
			finish_test;
		end
	endtask : rd

	// cycles until the next reset request must fall in lo..hi
	task automatic wait_req(input int lo, input int hi);
		int n;
		int c0;
		c0 = req_cnt;
		for (n = 1; n <= hi; n++) begin
			@(posedge sys_clk);
			#1;
			if (req_cnt != c0) break;
		end
		check(n >= lo && n <= hi, "reset request outside its window");
		req_base = req_cnt;
		if (n > hi) finish_test;
	endtask : wait_req

	// exactly k reset requests since the last look
	task automatic expect_req(input int k);
		repeat (2) @(posedge sys_clk);
		#1;
		check(req_cnt == req_base + k, "wrong number of reset requests");
		req_base = req_cnt;
	endtask : expect_req

	task automatic do_reset(input logic s);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		stoppable_strap <= s;
		halt_mode <= 1'b0;
		stop_mode <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		req_base = req_cnt;
	endtask : do_reset

	// ==========================================================
	// hang guard
	initial begin
		repeat (99000) @(posedge sys_clk);
		check(1'b0, "run out of time");
		finish_test;
	end

	// ==========================================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{low_speed_osc_clk, stoppable_strap, halt_mode, stop_mode} = 4'h8;
		osc_div = 2'h0;
		seed = 32'hDE63834E;
		{miscompares, n_tests, req_cnt, req_base} = '0;
		// stoppable personality: reset state and bus map
		do_reset(1'b1);
		rd(MODE_CFG_OFS, 32'h67, RESP_OKAY);
		rd(CLEAR_KEY_OFS, 32'h9A, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		rd(STATUS_OFS, 32'h05, RESP_OKAY);
		wr(MODE_CFG_OFS, 32'h68, 4'hE, RESP_OKAY);
		rd(MODE_CFG_OFS, 32'h67, RESP_OKAY);
		wr(CLEAR_KEY_OFS, 32'hAC, 4'hF, RESP_OKAY);
		expect_req(0);
		// system clock, shortest cycle, then overflow
		wr(MODE_CFG_OFS, 32'h68, 4'hF, RESP_OKAY);
		wait_req(8184, 8200);
		rd(MODE_CFG_OFS, 32'h68, RESP_OKAY);
		// halt holds the count for a random stretch
		wr(CLEAR_KEY_OFS, 32'hAC, 4'hF, RESP_OKAY);
		halt_mode <= 1'b1;
		seed = xs(seed);
		repeat (2000 + seed[10:0]) @(posedge sys_clk);
		halt_mode <= 1'b0;
		wait_req(8184, 8200);
		// stop holds the count, then a pause of 680 cycles
		wr(CLEAR_KEY_OFS, 32'hAC, 4'hF, RESP_OKAY);
		stop_mode <= 1'b1;
		repeat (50) @(posedge sys_clk);
		stop_mode <= 1'b0;
		rd(STATUS_OFS, 32'h16, RESP_OKAY);
		wait_req(8864, 8880);
		// violations each raise one reset request
		wr(MODE_CFG_OFS, 32'h69, 4'hF, RESP_OKAY);
		expect_req(1);
		seed = xs(seed);
		wr(CLEAR_KEY_OFS, {24'h0, seed[7:0] | 8'h01}, 4'hF, RESP_OKAY);
		expect_req(1);
		wr(CLEAR_BITOP_OFS, 32'hAC, 4'hF, RESP_OKAY);
		expect_req(1);
		wr(8'h14, 32'hAC, 4'hF, RESP_SLVERR);
		expect_req(0);
		// first write stops the unit: later faults are exempt
		do_reset(1'b1);
		wr(MODE_CFG_OFS, 32'h70, 4'hF, RESP_OKAY);
		rd(MODE_CFG_OFS, 32'h70, RESP_OKAY);
		wr(MODE_CFG_OFS, 32'h68, 4'hF, RESP_OKAY);
		wr(CLEAR_KEY_OFS, {24'h0, seed[7:0] | 8'h01}, 4'hF, RESP_OKAY);
		wr(CLEAR_BITOP_OFS, 32'hAC, 4'hF, RESP_OKAY);
		repeat (17000) @(posedge sys_clk);
		expect_req(0);
		rd(COUNT_OFS, 32'h0, RESP_OKAY);
		rd(STATUS_OFS, 32'h0E, RESP_OKAY);
		// fixed personality: clock bits ignored, counts in standby
		do_reset(1'b0);
		wr(MODE_CFG_OFS, 32'h78, 4'hF, RESP_OKAY);
		rd(MODE_CFG_OFS, 32'h60, RESP_OKAY);
		rd(STATUS_OFS, 32'h03, RESP_OKAY);
		halt_mode <= 1'b1;
		stop_mode <= 1'b1;
		repeat (8000) @(posedge sys_clk);
		wr(CLEAR_KEY_OFS, 32'hAC, 4'hF, RESP_OKAY);
		wait_req(16350, 16400);
		finish_test;
	end

endmodule : tb
